// *** shared/pps_pkg.sv ***
// constants for the port power status flag block
package pps_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFS_OTHER_STATUS = 8'h0f;
    localparam logic [7:0] OFS_INT_STATUS = 8'h10;
    localparam logic [7:0] OFS_GENERAL_STATUS = 8'h11;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int BIT_ERROR_STATE = 7;
    localparam int BIT_OVERCURRENT = 0;
    localparam int BIT_QUOTA = 7;
    localparam int BIT_CONST_CURRENT = 4;
    localparam int BIT_THERMAL = 3;
    localparam int BIT_LOW_CURRENT = 2;
    localparam int BIT_REMOVAL = 1;
    localparam int BIT_ATTACH = 0;
    // ************************************************************
    // flag vector slots
    // ************************************************************
    localparam int NUM_FLAGS = 6;
    localparam int FL_OVERCURRENT = 0;
    localparam int FL_QUOTA = 1;
    localparam int FL_THERMAL = 2;
    localparam int FL_LOW_CURRENT = 3;
    localparam int FL_REMOVAL = 4;
    localparam int FL_ATTACH = 5;
    // ************************************************************
    // reset values and encodings
    // ************************************************************
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic [1:0] QUOTA_ACT_HOST_INT = 2'h1;
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b01,
        ST_ERROR = 2'b10
    } pps_state_t;
endpackage : pps_pkg

// *** shared/pps_flag_if.sv ***
// carrier between the register logic and the sticky flag store
`timescale 1ns/10ps
`default_nettype none
interface pps_flag_if;
    logic [5:0] set;
    logic [5:0] clr;
    logic [5:0] q;
    modport store (input set, input clr, output q);
    modport user (output set, output clr, input q);
endinterface : pps_flag_if
`default_nettype wire

// *** src/pps_flag_store.sv ***
// sticky status flags with set-over-clear priority
`timescale 1ns/10ps
`default_nettype none
module pps_flag_store (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    pps_flag_if.store flags
);
    logic [5:0] q;
    logic [5:0] next_q;

    // ************************************************************
    // next value: a new event beats a same-cycle clear
    // ************************************************************
    always_comb begin
        next_q = flags.set | (q & ~flags.clr);
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= pps_pkg::FLAGS_RESET;
        end else begin
            q <= next_q;
        end
    end

    assign flags.q = q;
endmodule : pps_flag_store
`default_nettype wire

// *** src/pps_status_top.sv ***
// status flags, error state and alert / attach pins of a port power switch
// Behaviour
// - current past limit and region-2 minimum sets fault, alert, error state
// - reading fault clears it only once gone; clearing error clears it
// - error flag clears whenever the power switch enable is off
// - alert pin follows its own causes, not the error flag
// - quota reached sets bit 7; alerts only when action selects host
// - quota flag clears on read, counter clear, or quota disable
// - constant-current bit 4 is live current-over-limit, not read-cleared
// - thermal bit 3 clears on read; alerts only with escalate set
// - low-current bit 2 clears on read; alerts only with escalate set
// - removal bit 1 clears on read, no alert, releases attach pin
// - attach bit 0 clears on read, no alert, asserts attach pin
// - error clear rechecks conditions; active when all are gone or power switch enable is off
`timescale 1ns/10ps
`default_nettype none
module pps_status_top (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    input wire logic ibus_over_limit_in,
    input wire logic ibus_over_r2min_in,
    input wire logic other_fault_in,
    input wire logic auto_recovery_in,
    input wire logic power_switch_enable_in,
    input wire logic quota_done_in,
    input wire logic [1:0] quota_action_select_in,
    input wire logic quota_counter_clear_in,
    input wire logic quota_enable_in,
    input wire logic thermal_event_in,
    input wire logic low_current_event_in,
    input wire logic alert_escalate_in,
    input wire logic removal_event_in,
    input wire logic attach_event_in,
    output logic alert_n_out,
    output logic alert_oe_out,
    output logic attach_detect_n_pin_out,
    output logic attach_detect_n_pin_oe_out,
    output logic error_state_out
);
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] ofs,
                                 input logic strobe);
        hit = strobe && (addr == ofs);
    endfunction : hit

    pps_flag_if flags ();
    pps_flag_store u_flag_store (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .flags(flags)
    );

    pps_pkg::pps_state_t state;
    pps_pkg::pps_state_t next_state;
    logic [7:0] next_rdata;
    logic next_rvalid;
    logic next_alert;
    logic attach_drive;
    logic next_attach_drive;
    logic oc_cond;
    logic rd_int;
    logic rd_gen;
    logic err_clear;
    logic [5:0] set_v;
    logic [5:0] clr_v;

    // ************************************************************
    // conditions and read strobes
    // ************************************************************
    assign oc_cond = ibus_over_limit_in && ibus_over_r2min_in;
    assign rd_int = hit(reg_addr_in, pps_pkg::OFS_INT_STATUS, reg_rd_in);
    assign rd_gen = hit(reg_addr_in, pps_pkg::OFS_GENERAL_STATUS, reg_rd_in);

    // ************************************************************
    // error state machine
    // ************************************************************
    always_comb begin
        err_clear = 1'b0;
        next_state = state;
        unique case (state)
            pps_pkg::ST_ACTIVE: begin
                if (oc_cond || other_fault_in) begin
                    next_state = pps_pkg::ST_ERROR;
                end
            end
            pps_pkg::ST_ERROR: begin
                if (!power_switch_enable_in) begin
                    err_clear = 1'b1;
                end else if (hit(reg_addr_in, pps_pkg::OFS_OTHER_STATUS,
                                 reg_wr_in) &&
                             !reg_wdata_in[pps_pkg::BIT_ERROR_STATE]) begin
                    err_clear = 1'b1;
                end else if (auto_recovery_in && !oc_cond &&
                             !other_fault_in) begin
                    err_clear = 1'b1;
                end
                if (err_clear) begin
                    // recheck: fall back to active when all is gone or the switch enable is off
                    next_state = (oc_cond || other_fault_in) &&
                                 power_switch_enable_in ?
                                 pps_pkg::ST_ERROR :
                                 pps_pkg::ST_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= pps_pkg::ST_ACTIVE;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // flag set and clear terms
    // ************************************************************
    always_comb begin
        set_v = 6'h00;
        clr_v = 6'h00;
        set_v[pps_pkg::FL_OVERCURRENT] = oc_cond;
        set_v[pps_pkg::FL_QUOTA] = quota_done_in && quota_enable_in &&
                                   !quota_counter_clear_in;
        set_v[pps_pkg::FL_THERMAL] = thermal_event_in;
        set_v[pps_pkg::FL_LOW_CURRENT] = low_current_event_in;
        set_v[pps_pkg::FL_REMOVAL] = removal_event_in;
        set_v[pps_pkg::FL_ATTACH] = attach_event_in;
        clr_v[pps_pkg::FL_OVERCURRENT] = (rd_int && !oc_cond) ||
                                         err_clear;
        clr_v[pps_pkg::FL_QUOTA] = rd_gen || quota_counter_clear_in ||
                                   !quota_enable_in;
        clr_v[pps_pkg::FL_THERMAL] = rd_gen;
        clr_v[pps_pkg::FL_LOW_CURRENT] = rd_gen;
        clr_v[pps_pkg::FL_REMOVAL] = rd_gen;
        clr_v[pps_pkg::FL_ATTACH] = rd_gen;
    end

    assign flags.set = set_v;
    assign flags.clr = clr_v;

    // ************************************************************
    // read data, pre-clear values
    // ************************************************************
    always_comb begin
        next_rdata = 8'h00;
        next_rvalid = reg_rd_in;
        if (hit(reg_addr_in, pps_pkg::OFS_OTHER_STATUS, reg_rd_in)) begin
            next_rdata[pps_pkg::BIT_ERROR_STATE] =
                (state == pps_pkg::ST_ERROR);
        end
        if (rd_int) begin
            next_rdata[pps_pkg::BIT_OVERCURRENT] =
                flags.q[pps_pkg::FL_OVERCURRENT];
        end
        if (rd_gen) begin
            next_rdata[pps_pkg::BIT_QUOTA] = flags.q[pps_pkg::FL_QUOTA];
            next_rdata[pps_pkg::BIT_CONST_CURRENT] =
                ibus_over_limit_in;
            next_rdata[pps_pkg::BIT_THERMAL] = flags.q[pps_pkg::FL_THERMAL];
            next_rdata[pps_pkg::BIT_LOW_CURRENT] =
                flags.q[pps_pkg::FL_LOW_CURRENT];
            next_rdata[pps_pkg::BIT_REMOVAL] = flags.q[pps_pkg::FL_REMOVAL];
            next_rdata[pps_pkg::BIT_ATTACH] =
                flags.q[pps_pkg::FL_ATTACH];
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= pps_pkg::RDATA_RESET;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rdata_out <= next_rdata;
            reg_rvalid_out <= next_rvalid;
        end
    end

    // ************************************************************
    // alert and attach-detect pins
    // ************************************************************
    always_comb begin
        // alert tracks its own causes, never the error flag
        next_alert = flags.q[pps_pkg::FL_OVERCURRENT];
        if (flags.q[pps_pkg::FL_QUOTA] &&
            quota_action_select_in == pps_pkg::QUOTA_ACT_HOST_INT) begin
            next_alert = 1'b1;
        end
        if (alert_escalate_in && (flags.q[pps_pkg::FL_THERMAL] ||
                                  flags.q[pps_pkg::FL_LOW_CURRENT])) begin
            next_alert = 1'b1;
        end
        next_attach_drive = attach_drive;
        if (removal_event_in) begin
            next_attach_drive = 1'b0;
        end
        if (attach_event_in) begin
            next_attach_drive = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            alert_oe_out <= 1'b0;
            attach_drive <= 1'b0;
            attach_detect_n_pin_oe_out <= 1'b0;
            error_state_out <= 1'b0;
        end else begin
            alert_oe_out <= next_alert;
            attach_drive <= next_attach_drive;
            attach_detect_n_pin_oe_out <= next_attach_drive;
            error_state_out <= (next_state == pps_pkg::ST_ERROR);
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            alert_n_out <= 1'b0;
            attach_detect_n_pin_out <= 1'b0;
        end else begin
            alert_n_out <= 1'b0;
            attach_detect_n_pin_out <= 1'b0;
        end
    end
endmodule : pps_status_top
`default_nettype wire

// *** testbench/pps_status_chk.sv ***
// port-level assertions for the status flag block
`timescale 1ns/10ps
`default_nettype none
module pps_status_chk (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic ibus_over_limit_in,
    input wire logic ibus_over_r2min_in,
    input wire logic other_fault_in,
    input wire logic auto_recovery_in,
    input wire logic power_switch_enable_in,
    input wire logic removal_event_in,
    input wire logic attach_event_in,
    input wire logic alert_oe_out,
    input wire logic attach_detect_n_pin_oe_out,
    input wire logic error_state_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence s_oc;
        ibus_over_limit_in && ibus_over_r2min_in && power_switch_enable_in;
    endsequence
    sequence s_gs_rd;
        reg_rd_in && reg_addr_in == pps_pkg::OFS_GENERAL_STATUS;
    endsequence
    read_answer_a: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered");
    unused_zero_a: assert property (
        s_gs_rd |=> reg_rdata_out[6:5] == 2'h0)
        else $error("bits 6 and 5 not zero");
    live_cc_a: assert property (
        s_gs_rd |=> reg_rdata_out[4] == $past(ibus_over_limit_in))
        else $error("constant-current bit not live");
    oc_error_a: assert property (s_oc [*2] |=> error_state_out)
        else $error("no error state on overcurrent");
    oc_alert_a: assert property (s_oc [*3] |=> alert_oe_out)
        else $error("no alert on overcurrent");
    error_hold_a: assert property (
        error_state_out && !auto_recovery_in && power_switch_enable_in &&
        !reg_wr_in |=> error_state_out)
        else $error("error state left by itself");
    power_clear_a: assert property (!power_switch_enable_in &&
        !ibus_over_limit_in && !other_fault_in |=> !error_state_out)
        else $error("error kept with power off");
    attach_pin_a: assert property (
        attach_event_in |=> attach_detect_n_pin_oe_out)
        else $error("attach pin not asserted");
    removal_pin_a: assert property (
        removal_event_in && !attach_event_in |=> !attach_detect_n_pin_oe_out)
        else $error("attach pin not released");
endmodule : pps_status_chk
`default_nettype wire

// *** testbench/pps_host.sv ***
// host side of the register strobes
`timescale 1ns/10ps
`default_nettype none
module pps_host (
    input wire logic ref_clk_in,
    output logic [7:0] addr_out,
    output logic rd_out,
    output logic wr_out,
    output logic [7:0] wdata_out
);
    initial begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        rd_out = 0;
        wr_out = 0;
    end
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [7:0] d);
        @(posedge ref_clk_in);
        #1 addr_out = a;
        wdata_out = d;
        wr_out = w;
        rd_out = !w;
        @(posedge ref_clk_in);
        #1 rd_out = 0;
        wr_out = 0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask : xfer
endmodule : pps_host
`default_nettype wire

// *** testbench/port_power_status_flags_bench.sv ***
// self-checking bench for the port power status flags
`timescale 1ns/10ps
`default_nettype none
module port_power_status_flags_bench;
    logic ref_clk_in = 0, rst_n_in = 0, other_fault_in = 0;
    logic [4:0] ev = 5'h00;
    logic ibus_over_limit_in = 0, ibus_over_r2min_in = 0;
    logic auto_recovery_in = 0, power_switch_enable_in = 1;
    logic quota_enable_in = 1, quota_counter_clear_in = 0;
    logic alert_escalate_in = 0;
    logic [1:0] quota_action_select_in = 2'h1;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic reg_rd_in, reg_wr_in, reg_rvalid_out, alert_n_out, alert_oe_out;
    logic attach_detect_n_pin_out, attach_detect_n_pin_oe_out, error_state_out;
    wire logic thermal_event_in = ev[0];
    wire logic low_current_event_in = ev[1];
    wire logic removal_event_in = ev[2];
    wire logic attach_event_in = ev[3];
    wire logic quota_done_in = ev[4];
    logic [7:0] exp_q[$];
    int n_errors = 0, n_checks = 0;
    initial forever #2 ref_clk_in = ~ref_clk_in;
    pps_status_top dut (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr_in),
        .reg_rd_in(reg_rd_in),
        .reg_wr_in(reg_wr_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out),
        .reg_rvalid_out(reg_rvalid_out),
        .ibus_over_limit_in(ibus_over_limit_in),
        .ibus_over_r2min_in(ibus_over_r2min_in),
        .other_fault_in(other_fault_in),
        .auto_recovery_in(auto_recovery_in),
        .power_switch_enable_in(power_switch_enable_in),
        .quota_done_in(quota_done_in),
        .quota_action_select_in(quota_action_select_in),
        .quota_counter_clear_in(quota_counter_clear_in),
        .quota_enable_in(quota_enable_in),
        .thermal_event_in(thermal_event_in),
        .low_current_event_in(low_current_event_in),
        .alert_escalate_in(alert_escalate_in),
        .removal_event_in(removal_event_in),
        .attach_event_in(attach_event_in),
        .alert_n_out(alert_n_out),
        .alert_oe_out(alert_oe_out),
        .attach_detect_n_pin_out(attach_detect_n_pin_out),
        .attach_detect_n_pin_oe_out(attach_detect_n_pin_oe_out),
        .error_state_out(error_state_out)
    );
    pps_host h (.ref_clk_in(ref_clk_in), .addr_out(reg_addr_in),
        .rd_out(reg_rd_in), .wr_out(reg_wr_in), .wdata_out(reg_wdata_in));
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        h.xfer(a, 1'b0, 8'h00);
    endtask : rd
    task automatic pulse(input int k);
        @(posedge ref_clk_in) #1 ev[k] = 1;
        @(posedge ref_clk_in) #1 ev[k] = 0;
    endtask : pulse
    task automatic conclude;
        if (exp_q.size() != 0) n_errors++;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    always @(negedge ref_clk_in) begin
        if (reg_rvalid_out === 1'b1) begin
            if (exp_q.size() == 0) chk("rvalid", 8'h00, 8'h01);
            else chk("rdata", exp_q.pop_front(), reg_rdata_out);
        end
    end
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        n_errors++;
        conclude();
    end
    initial begin
        void'($urandom(32'h92c4));
        repeat (3) @(posedge ref_clk_in);
        #1 rst_n_in = 1;
        for (int a = 15; a < 18; a++) rd(8'(a), 8'h00);
        $display("reset values done");
        for (int j = 0; j < 2; j++) begin
            alert_escalate_in = j[0];
            for (int k = 0; k < 4; k++) begin
                pulse(k);
                repeat (2) @(posedge ref_clk_in);
                #1 chk("alert", 8'(k < 2 && j == 1),
                    {7'h00, alert_oe_out});
                if (k > 1) chk("adet", 8'(k == 3),
                    {7'h00, attach_detect_n_pin_oe_out});
                rd(8'h11, 8'h08 >> k);
                rd(8'h11, 8'h00);
            end
        end
        pulse(3);
        h.xfer(8'h11, 1'b1, 8'hff);
        fork
            pulse(3);
            rd(8'h11, 8'h01);
        join
        rd(8'h11, 8'h01);
        $display("event flags done");
        for (int s = 0; s < 4; s++) begin
            quota_action_select_in = 2'(s);
            pulse(4);
            repeat (2) @(posedge ref_clk_in);
            #1 chk("quota alert", 8'(s == 1), {7'h00, alert_oe_out});
            rd(8'h11, 8'h80);
        end
        for (int c = 0; c < 2; c++) begin
            pulse(4);
            {quota_counter_clear_in, quota_enable_in} = c[0] ? 2'b11 : 2'b00;
            @(posedge ref_clk_in);
            #1 {quota_counter_clear_in, quota_enable_in} = 2'b01;
            rd(8'h11, 8'h00);
        end
        $display("quota done");
        {ibus_over_limit_in, ibus_over_r2min_in} = 2'b11;
        repeat (3) @(posedge ref_clk_in);
        #1 chk("error", 8'h01, {7'h00, error_state_out});
        chk("oc alert", 8'h01, {7'h00, alert_oe_out});
        rd(8'h10, 8'h01);
        rd(8'h11, 8'h10);
        h.xfer(8'h0f, 1'b1, 8'h00);
        {ibus_over_limit_in, ibus_over_r2min_in} = 2'b00;
        rd(8'h10, 8'h01);
        repeat (3) @(posedge ref_clk_in);
        #1 chk("error held", 8'h01, {7'h00, error_state_out});
        chk("alert apart", 8'h00, {7'h00, alert_oe_out});
        chk("pin data", 8'h00,
            {6'h00, alert_n_out, attach_detect_n_pin_out});
        for (int p = 0; p < 3; p++) begin
            auto_recovery_in = (p == 2);
            {ibus_over_limit_in, ibus_over_r2min_in} = 2'b11;
            repeat (3) @(posedge ref_clk_in);
            #1 {ibus_over_limit_in, ibus_over_r2min_in} = 2'b00;
            if (p == 1) power_switch_enable_in = 0;
            else if (p == 0) h.xfer(8'h0f, 1'b1, 8'h00);
            repeat (3) @(posedge ref_clk_in);
            #1 chk("error off", 8'h00,
                {7'h00, error_state_out});
            power_switch_enable_in = 1;
            rd(8'h10, 8'h00);
        end
        $display("error state done");
        repeat (20) begin
            repeat ($urandom_range(2)) @(posedge ref_clk_in);
            h.xfer(8'($urandom_range(255, 16)), 1'b1, 8'($urandom));
            rd(8'($urandom_range(255, 18)), 8'h00);
        end
        rd(8'h11, 8'h00);
        repeat (4) @(posedge ref_clk_in);
        $display("random access done");
        conclude();
    end
endmodule : port_power_status_flags_bench
bind pps_status_top pps_status_chk chk (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in),
    .reg_rd_in(reg_rd_in),
    .reg_wr_in(reg_wr_in),
    .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out),
    .ibus_over_limit_in(ibus_over_limit_in),
    .ibus_over_r2min_in(ibus_over_r2min_in),
    .other_fault_in(other_fault_in),
    .auto_recovery_in(auto_recovery_in),
    .power_switch_enable_in(power_switch_enable_in),
    .removal_event_in(removal_event_in),
    .attach_event_in(attach_event_in),
    .alert_oe_out(alert_oe_out),
    .attach_detect_n_pin_oe_out(attach_detect_n_pin_oe_out),
    .error_state_out(error_state_out)
);
`default_nettype wire
